// file: design/spls_core.sv
// Digital core: serial load, latches, dividers, phase/frequency detector, APB.
// Assumes the link pins are asynchronous to MCLK and slower than MCLK/4; APB pins are used as synchronous to MCLK.
`timescale 1ns/10ps
`default_nettype none
`include "spls_defs.svh"
module spls_core
(
    input wire logic MCLK,
    input wire logic ARST_N,
    input wire logic SER_CLK,
    input wire logic SER_DATA,
    input wire logic LATCH_STROBE,
    input wire logic [2:0] REF_SELECT,
    input wire logic FREQ_IN,
    input wire logic OSCILLATOR_INPUT,
    output logic OSCILLATOR_OUTPUT,
    output logic BUFFERED_REFERENCE_OUT,
    output logic SINGLE_ENDED_ERROR_OUT,
    output logic SINGLE_ENDED_ERROR_OE,
    output logic FB_ERROR_N,
    output logic REF_ERROR_N,
    output logic LOCK_INDICATOR,
    output logic BAND_SWITCH_ONE_OUT,
    output logic BAND_SWITCH_ONE_OE,
    output logic BAND_SWITCH_TWO_OUT,
    output logic BAND_SWITCH_TWO_OE,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic IRQ
);

    // Reference ratio lookup by select code.
    function automatic logic [`SPLS_REF_W-1:0] ref_ratio(input logic [2:0] code);
        case (code)
            3'h0: ref_ratio = `SPLS_REF_0;
            3'h1: ref_ratio = `SPLS_REF_1;
            3'h2: ref_ratio = `SPLS_REF_2;
            3'h3: ref_ratio = `SPLS_REF_3;
            3'h4: ref_ratio = `SPLS_REF_4;
            3'h5: ref_ratio = `SPLS_REF_5;
            3'h6: ref_ratio = `SPLS_REF_6;
            default: ref_ratio = `SPLS_REF_7;
        endcase
    endfunction

    // ======================================================================
    // Pin synchronisers
    // ======================================================================
    // Bits: 0 ser clk, 1 ser data, 2 strobe, 3-5 select, 6 freq, 7 osc.
    logic [7:0] sync1_r;
    logic [7:0] sync2_r;
    logic [7:0] sync3_r;
    logic [7:0] pins;
    assign pins = {OSCILLATOR_INPUT, FREQ_IN, REF_SELECT, LATCH_STROBE, SER_DATA, SER_CLK};

    // Two stages guard against metastability; the third only feeds edge detects.
    always_ff @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            sync1_r <= 8'h04;
            sync2_r <= 8'h04;
            sync3_r <= 8'h04;
        end
        else
        begin
            sync1_r <= pins;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    logic ser_rise;
    logic fin_rise;
    logic osc_rise;
    logic strobe;
    assign ser_rise = sync2_r[0] & ~sync3_r[0];
    assign fin_rise = sync2_r[6] & ~sync3_r[6];
    assign osc_rise = sync2_r[7] & ~sync3_r[7];
    // strobe default high: an open pin is modelled as pulled up by the pad.
    assign strobe = sync2_r[2];

    // ======================================================================
    // Shift register and latches
    // ======================================================================
    logic [`SPLS_WORD_W-1:0] shift_r;
    logic [`SPLS_WORD_W-1:0] shift_nxt;
    spls_pkg::spls_word_type latch_r;
    spls_pkg::spls_word_type latch_nxt;
    logic load_ev;

    always_comb
    begin
        shift_nxt = shift_r;
        latch_nxt = latch_r;
        // shift in MSB first: last bit lands in bit 0.
        if (ser_rise)
            shift_nxt = {shift_r[`SPLS_WORD_W-2:0], sync2_r[1]};
        // latch follows while strobe high only.
        if (strobe)
            latch_nxt = shift_nxt;
        load_ev = strobe && (latch_nxt != latch_r);
    end

    always_ff @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            shift_r <= `SPLS_WORD_RST;
            latch_r <= `SPLS_WORD_RST;
        end
        else
        begin
            shift_r <= shift_nxt;
            latch_r <= latch_nxt;
        end
    end

    // ======================================================================
    // Reference and feedback dividers
    // ======================================================================
    logic [`SPLS_REF_W-1:0] ref_cnt_r;
    logic [`SPLS_REF_W-1:0] ref_cnt_nxt;
    logic [`SPLS_DIV_W-1:0] fb_cnt_r;
    logic [`SPLS_DIV_W-1:0] fb_cnt_nxt;
    logic ref_pulse;
    logic fb_pulse;
    logic [`SPLS_DIV_W-1:0] div_val;

    always_comb
    begin
        ref_cnt_nxt = ref_cnt_r;
        fb_cnt_nxt = fb_cnt_r;
        ref_pulse = 1'b0;
        fb_pulse = 1'b0;
        // ratios below 3 are clamped to the least legal ratio.
        div_val = (latch_r.divide < `SPLS_DIV_MIN) ? `SPLS_DIV_MIN : latch_r.divide;
        // one reference pulse per completed division.
        if (osc_rise)
        begin
            if (ref_cnt_r >= ref_ratio(sync2_r[5:3]) - 14'h0001)
            begin
                ref_cnt_nxt = 14'h0000;
                ref_pulse = 1'b1;
            end
            else
                ref_cnt_nxt = ref_cnt_r + 14'h0001;
        end
        // count down, reload latched value at end count.
        if (fin_rise)
        begin
            if (fb_cnt_r <= 14'h0001)
            begin
                fb_cnt_nxt = div_val;
                fb_pulse = 1'b1;
            end
            else
                fb_cnt_nxt = fb_cnt_r - 14'h0001;
        end
    end

    always_ff @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            ref_cnt_r <= 14'h0000;
            fb_cnt_r <= 14'h0003;
        end
        else
        begin
            ref_cnt_r <= ref_cnt_nxt;
            fb_cnt_r <= fb_cnt_nxt;
        end
    end

    // ======================================================================
    // Phase/frequency detector
    // ======================================================================
    // Whichever edge arrives first opens its error pulse; the other closes it.
    // Coincident edges give the brief joint pulse that a locked loop shows.
    spls_pkg::spls_pd_state_type pd_r;
    spls_pkg::spls_pd_state_type pd_nxt;
    logic [1:0] pulse_cnt_r;
    logic [1:0] pulse_cnt_nxt;
    spls_pkg::spls_pd_type pd_out;
    logic fb_lead_ev;
    logic ref_lead_ev;

    always_comb
    begin
        pd_nxt = pd_r;
        pulse_cnt_nxt = pulse_cnt_r;
        fb_lead_ev = 1'b0;
        ref_lead_ev = 1'b0;
        case (pd_r)
            spls_pkg::PD_IDLE:
            begin
                if (ref_pulse && fb_pulse)
                begin
                    pd_nxt = spls_pkg::PD_BOTH;
                    pulse_cnt_nxt = 2'(`SPLS_MIN_PULSE_CYC);
                end
                else if (fb_pulse)
                begin
                    pd_nxt = spls_pkg::PD_FB_LEAD;
                    fb_lead_ev = 1'b1;
                end
                else if (ref_pulse)
                begin
                    pd_nxt = spls_pkg::PD_REF_LEAD;
                    ref_lead_ev = 1'b1;
                end
            end
            spls_pkg::PD_FB_LEAD:
            begin
                if (ref_pulse)
                begin
                    pd_nxt = spls_pkg::PD_BOTH;
                    pulse_cnt_nxt = 2'(`SPLS_MIN_PULSE_CYC);
                end
            end
            spls_pkg::PD_REF_LEAD:
            begin
                if (fb_pulse)
                begin
                    pd_nxt = spls_pkg::PD_BOTH;
                    pulse_cnt_nxt = 2'(`SPLS_MIN_PULSE_CYC);
                end
            end
            spls_pkg::PD_BOTH:
            begin
                if (pulse_cnt_r <= 2'h1)
                    pd_nxt = spls_pkg::PD_IDLE;
                else
                    pulse_cnt_nxt = pulse_cnt_r - 2'h1;
            end
            default: pd_nxt = spls_pkg::PD_IDLE;
        endcase
        // error outputs low per leading side.
        pd_out.fb_err_n = !(pd_nxt == spls_pkg::PD_FB_LEAD || pd_nxt == spls_pkg::PD_BOTH);
        pd_out.ref_err_n = !(pd_nxt == spls_pkg::PD_REF_LEAD || pd_nxt == spls_pkg::PD_BOTH);
        // lock low only while one side leads.
        pd_out.lock = pd_out.fb_err_n == pd_out.ref_err_n;
    end

    always_ff @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            pd_r <= spls_pkg::PD_IDLE;
            pulse_cnt_r <= 2'h0;
        end
        else
        begin
            pd_r <= pd_nxt;
            pulse_cnt_r <= pulse_cnt_nxt;
        end
    end

    // ======================================================================
    // Pin outputs
    // ======================================================================
    always_ff @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            FB_ERROR_N <= 1'b1;
            REF_ERROR_N <= 1'b1;
            LOCK_INDICATOR <= 1'b1;
            SINGLE_ENDED_ERROR_OUT <= 1'b0;
            SINGLE_ENDED_ERROR_OE <= 1'b0;
            BAND_SWITCH_ONE_OUT <= 1'b0;
            BAND_SWITCH_ONE_OE <= 1'b0;
            BAND_SWITCH_TWO_OUT <= 1'b0;
            BAND_SWITCH_TWO_OE <= 1'b0;
            BUFFERED_REFERENCE_OUT <= 1'b0;
            OSCILLATOR_OUTPUT <= 1'b1;
        end
        else
        begin
            FB_ERROR_N <= pd_out.fb_err_n;
            REF_ERROR_N <= pd_out.ref_err_n;
            LOCK_INDICATOR <= pd_out.lock;
            // drive low when fast, high when slow, else float.
            SINGLE_ENDED_ERROR_OUT <= pd_out.fb_err_n;
            SINGLE_ENDED_ERROR_OE <= pd_out.fb_err_n ^ pd_out.ref_err_n;
            // open drain: bit one floats, bit zero pulls low.
            BAND_SWITCH_ONE_OUT <= 1'b0;
            BAND_SWITCH_ONE_OE <= ~latch_nxt.sw1;
            BAND_SWITCH_TWO_OUT <= 1'b0;
            BAND_SWITCH_TWO_OE <= ~latch_nxt.sw2;
            // buffered reference copy, inverted as the oscillator feedback.
            BUFFERED_REFERENCE_OUT <= sync2_r[7];
            OSCILLATOR_OUTPUT <= ~sync2_r[7];
        end
    end

    // ======================================================================
    // APB registers and interrupt
    // ======================================================================
    // Zero wait states: PREADY is held high, reads answer in the access cycle.
    logic [`SPLS_ST_W-1:0] status_r;
    logic [`SPLS_ST_W-1:0] status_nxt;
    logic [`SPLS_ST_W-1:0] mask_r;
    logic [`SPLS_ST_W-1:0] mask_nxt;
    logic [31:0] rdata_nxt;
    logic slverr_nxt;
    logic acc;
    logic wr_acc;
    logic [`SPLS_ST_W-1:0] events;
    assign acc = PSEL && !PENABLE;
    assign wr_acc = PSEL && PENABLE && PREADY && PWRITE;
    assign events = {ref_lead_ev, fb_lead_ev, fb_lead_ev | ref_lead_ev, load_ev};

    always_comb
    begin
        status_nxt = status_r;
        mask_nxt = mask_r;
        rdata_nxt = PRDATA;
        slverr_nxt = 1'b0;
        // Setup-phase decode so data is registered for the access cycle.
        if (acc)
        begin
            rdata_nxt = 32'h0000_0000;
            case (PADDR)
                `SPLS_ADDR_STATUS: rdata_nxt = {28'h0, status_r};
                `SPLS_ADDR_MASK: rdata_nxt = {28'h0, mask_r};
                `SPLS_ADDR_WORD: rdata_nxt = {16'h0, latch_r};
                default: slverr_nxt = 1'b1;
            endcase
        end
        // Writes land at the access edge, where the master sees PREADY high.
        if (wr_acc && PADDR == `SPLS_ADDR_STATUS)
            status_nxt = status_r & ~PWDATA[`SPLS_ST_W-1:0];
        if (wr_acc && PADDR == `SPLS_ADDR_MASK)
            mask_nxt = PWDATA[`SPLS_ST_W-1:0];
        // Set wins over a write-one clear in the same cycle.
        status_nxt = status_nxt | events;
    end

    always_ff @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            status_r <= 4'h0;
            mask_r <= `SPLS_MASK_RST;
            PRDATA <= 32'h0000_0000;
            PSLVERR <= 1'b0;
            PREADY <= 1'b0;
            IRQ <= 1'b0;
        end
        else
        begin
            status_r <= status_nxt;
            mask_r <= mask_nxt;
            PRDATA <= rdata_nxt;
            PSLVERR <= slverr_nxt;
            PREADY <= 1'b1;
            IRQ <= |(status_nxt & mask_nxt);
        end
    end

endmodule
`default_nettype wire

// file: design/spls_defs.svh
// Constants for the serial-programmed synthesizer core.
// Assumes a 100 MHz MCLK; every link pin is sampled by that clock.
// How it works
// - Each rising serial clock edge shifts one data bit into 16-bit register.
// - Shift word holds 14-bit divide value plus two switch bits.
// - Strobe high copies shift register into the holding latches.
// - Strobe low leaves latches unchanged while new data shifts in.
// - An undriven strobe reads high, so latches follow continuously.
// - Three select pins choose reference ratio 16 up to 8192.
// - Feedback divider supports ratios 3 through 16383.
// - Three-state output pulses low when fast, high when slow, floats otherwise.
// - Feedback fast or leading pulses feedback-side error output low.
// - Feedback slow or lagging pulses reference-side error output low.
// - In lock both error outputs stay high but for brief joint pulse.
// - Lock indicator high in lock, pulses low when out of lock.
// - Each band switch is latched open drain from its own bit.
// - Switch bit one floats the output, bit zero pulls it low.
// - Buffered copy of reference oscillator appears on a dedicated output.
`ifndef SPLS_DEFS_SVH
`define SPLS_DEFS_SVH

// ==========================================================================
// Word layout
// ==========================================================================
`define SPLS_WORD_W 16
`define SPLS_DIV_W 14
`define SPLS_SW1_BIT 15
`define SPLS_SW2_BIT 14
`define SPLS_DIV_MIN 14'h0003

// ==========================================================================
// Reference ratios
// ==========================================================================
`define SPLS_REF_W 14
`define SPLS_REF_0 14'h0010
`define SPLS_REF_1 14'h0200
`define SPLS_REF_2 14'h0400
`define SPLS_REF_3 14'h0800
`define SPLS_REF_4 14'h0E54
`define SPLS_REF_5 14'h1000
`define SPLS_REF_6 14'h1800
`define SPLS_REF_7 14'h2000

// ==========================================================================
// Register map and reset values
// ==========================================================================
`define SPLS_ADDR_STATUS 12'h000
`define SPLS_ADDR_MASK 12'h004
`define SPLS_ADDR_WORD 12'h008
`define SPLS_ST_LOAD 0
`define SPLS_ST_UNLOCK 1
`define SPLS_ST_FB 2
`define SPLS_ST_REF 3
`define SPLS_ST_W 4
`define SPLS_MASK_RST 4'h0
`define SPLS_WORD_RST 16'hFFFF

// ==========================================================================
// Timing
// ==========================================================================
`define SPLS_MIN_PULSE_NS 20
`define SPLS_CLK_NS 10
`define SPLS_MIN_PULSE_CYC ((`SPLS_MIN_PULSE_NS + `SPLS_CLK_NS - 1) / `SPLS_CLK_NS)

`endif

// file: design/spls_pkg.sv
// Types shared by the synthesizer core.
// Assumes spls_defs.svh is compiled alongside.
`include "spls_defs.svh"
package spls_pkg;
    // Latched programming word split into its fields.
    typedef struct packed
    {
        logic sw1;
        logic sw2;
        logic [`SPLS_DIV_W-1:0] divide;
    } spls_word_type;

    // Phase detector outputs carried together.
    typedef struct packed
    {
        logic fb_err_n;
        logic ref_err_n;
        logic lock;
    } spls_pd_type;

    // Detector state.
    typedef enum logic [1:0] {PD_IDLE, PD_FB_LEAD, PD_REF_LEAD, PD_BOTH} spls_pd_state_type;
endpackage

// file: test/spls_core_props.sv
// =====================================================================
// Concurrent checks on the pins of the synthesizer core.
// Assumes it is bound to spls_core and that all pins share MCLK.
`timescale 1ns/10ps
`default_nettype none
`include "spls_defs.svh"
module spls_core_props
(
    input wire logic MCLK,
    input wire logic ARST_N,
    input wire logic LATCH_STROBE,
    input wire logic OSCILLATOR_INPUT,
    input wire logic OSCILLATOR_OUTPUT,
    input wire logic BUFFERED_REFERENCE_OUT,
    input wire logic SINGLE_ENDED_ERROR_OUT,
    input wire logic SINGLE_ENDED_ERROR_OE,
    input wire logic FB_ERROR_N,
    input wire logic REF_ERROR_N,
    input wire logic LOCK_INDICATOR,
    input wire logic BAND_SWITCH_ONE_OUT,
    input wire logic BAND_SWITCH_ONE_OE,
    input wire logic BAND_SWITCH_TWO_OUT,
    input wire logic BAND_SWITCH_TWO_OE,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic PREADY,
    input wire logic IRQ
);
    // One domain, so reset silences every check in one place.
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!ARST_N);

    // Coincident edges: one more joint low cycle, then both released.
    sequence s_joint_low;
        !FB_ERROR_N && !REF_ERROR_N ##1 FB_ERROR_N && REF_ERROR_N;
    endsequence
    // Eight low cycles outlast the strobe synchronizer and the output stage.
    sequence s_strobe_quiet;
        (!LATCH_STROBE) [*8];
    endsequence

    AST_SW_LOW: assert property (!BAND_SWITCH_ONE_OUT && !BAND_SWITCH_TWO_OUT)
        else $error("band switch drives high");
    AST_SW_HOLD: assert property (s_strobe_quiet |-> $stable(BAND_SWITCH_ONE_OE)
        && $stable(BAND_SWITCH_TWO_OE)) else $error("switch moved, strobe low");
    AST_FLOAT: assert property (SINGLE_ENDED_ERROR_OE |-> FB_ERROR_N != REF_ERROR_N)
        else $error("three-state output driven without one-sided error");
    AST_FB_LEAD: assert property (!FB_ERROR_N && REF_ERROR_N |->
        SINGLE_ENDED_ERROR_OE && !SINGLE_ENDED_ERROR_OUT) else $error("no negative pulse");
    AST_REF_LEAD: assert property (FB_ERROR_N && !REF_ERROR_N |->
        SINGLE_ENDED_ERROR_OE && SINGLE_ENDED_ERROR_OUT) else $error("no positive pulse");
    AST_JOINT: assert property (!FB_ERROR_N && !REF_ERROR_N
        && ($fell(FB_ERROR_N) || $fell(REF_ERROR_N)) |=> s_joint_low)
        else $error("joint pulse width wrong");
    AST_LOCK: assert property ($fell(LOCK_INDICATOR) |-> FB_ERROR_N != REF_ERROR_N
        || $past(FB_ERROR_N) != $past(REF_ERROR_N)) else $error("lock low while locked");
    AST_REF_BUF: assert property ($past(ARST_N, 4) |->
        BUFFERED_REFERENCE_OUT == $past(OSCILLATOR_INPUT, 3)) else $error("reference copy");
    AST_OSC_INV: assert property (OSCILLATOR_OUTPUT != BUFFERED_REFERENCE_OUT)
        else $error("oscillator output not the inverse of the reference copy");
    AST_ZERO_WAIT: assert property (PSEL && !PENABLE |=> PREADY)
        else $error("bus answer late");
    AST_MASK_OFF: assert property (PSEL && PENABLE && PREADY && PWRITE
        && PADDR == `SPLS_ADDR_MASK && PWDATA[3:0] == 4'h0 |-> ##2 !IRQ)
        else $error("interrupt with all masked");
endmodule

bind spls_core spls_core_props u_props
(
    .MCLK, .ARST_N, .LATCH_STROBE, .OSCILLATOR_INPUT, .OSCILLATOR_OUTPUT,
    .BUFFERED_REFERENCE_OUT,
    .SINGLE_ENDED_ERROR_OUT, .SINGLE_ENDED_ERROR_OE, .FB_ERROR_N, .REF_ERROR_N,
    .LOCK_INDICATOR, .BAND_SWITCH_ONE_OUT, .BAND_SWITCH_ONE_OE, .BAND_SWITCH_TWO_OUT,
    .BAND_SWITCH_TWO_OE, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PREADY, .IRQ
);
`default_nettype wire

// file: test/spls_host_model.sv
// =====================================================================
// Host controller model: serial clock, data and latch strobe.
// Assumes MCLK from the bench; every pin changes by NBA at its rising edge.
`timescale 1ns/10ps
`default_nettype none
module spls_host_model
(
    input wire logic mclk,
    output logic ser_clk,
    output logic ser_data,
    output logic latch_strobe
);
    logic st_en = 1'b1;
    logic st_val = 1'b0;

    // Idle clock stands low; data starts at a defined level.
    initial
    begin
        ser_clk <= 1'b0;
        ser_data <= 1'b0;
    end

    assign latch_strobe = st_en ? st_val : 1'b1;

    // MSB first; strobe held low only when hold_low
    // Four MCLK cycles a phase give the 80 ns link clock period.
    task automatic send(input logic [15:0] w, input logic hold_low);
        @(posedge mclk);
        if (hold_low)
        begin
            st_en <= 1'b1;
            st_val <= 1'b0;
        end
        for (int i = 15; i >= 0; i--)
        begin
            ser_data <= w[i];
            repeat (4) @(posedge mclk);
            ser_clk <= 1'b1;
            repeat (4) @(posedge mclk);
            ser_clk <= 1'b0;
        end
        // Released data shows the inverse so no stale bit looks valid.
        ser_data <= ~w[0];
        repeat (4) @(posedge mclk);
    endtask

    task automatic pulse();
        @(posedge mclk);
        st_val <= 1'b1;
        repeat (8) @(posedge mclk);
        st_val <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask

    // Letting go of the strobe leaves it to the pull-up.
    task automatic release_strobe();
        @(posedge mclk);
        st_en <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask
endmodule
`default_nettype wire

// file: test/testbench.sv
// =====================================================================
// Self-checking bench for the synthesizer core over APB and serial pins.
// Assumes the host model and the bound checker are compiled with it.
`timescale 1ns/10ps
`default_nettype none
`include "spls_defs.svh"
module testbench;
    localparam logic [32:0] ALL = 33'h1FFFFFFFF;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic osc = 1'b0;
    logic fin = 1'b0;
    logic [2:0] tick = 3'h0;
    logic fin_on = 1'b0;
    logic [2:0] rsel = 3'h0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [15:0] w1;
    logic [15:0] w2;
    logic [65:0] notes[$];
    int mismatches = 0;
    int cmp_count = 0;
    wire ser_clk, ser_data, strobe, pready, pslverr, irq, sw1_oe, sw2_oe;
    wire [31:0] prdata;

    spls_host_model host
    (
        .mclk(mclk), .ser_clk(ser_clk), .ser_data(ser_data), .latch_strobe(strobe)
    );

    spls_core dut
    (
        .MCLK(mclk), .ARST_N(arst_n), .SER_CLK(ser_clk), .SER_DATA(ser_data),
        .LATCH_STROBE(strobe), .REF_SELECT(rsel), .FREQ_IN(fin), .OSCILLATOR_INPUT(osc),
        .OSCILLATOR_OUTPUT(), .BUFFERED_REFERENCE_OUT(), .SINGLE_ENDED_ERROR_OUT(),
        .SINGLE_ENDED_ERROR_OE(), .FB_ERROR_N(), .REF_ERROR_N(), .LOCK_INDICATOR(),
        .BAND_SWITCH_ONE_OUT(), .BAND_SWITCH_ONE_OE(sw1_oe), .BAND_SWITCH_TWO_OUT(),
        .BAND_SWITCH_TWO_OE(sw2_oe), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .IRQ(irq)
    );

    // 100 MHz system clock.
    always #5 mclk = ~mclk;

    // Oscillator and feedback both at 80 ns, offset so their edges differ.
    // Feedback waits for the first word: a reload of the reset ratio lasts 131k cycles.
    always @(posedge mclk)
    begin
        tick <= tick + 3'h1;
        osc <= tick[2];
        fin <= fin_on & (tick[2] ^ tick[1]);
    end

    task automatic close_out();
        if (mismatches == 0 && cmp_count > 0)
        begin
            $display("Test passed");
        end
        else
        begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Note layout: mask in the upper half, error flag and data below.
    task automatic cmp_rd(input logic [32:0] got, input logic [65:0] n);
        cmp_count++;
        if ((got & n[65:33]) !== n[32:0])
        begin
            mismatches++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, n[32:0], got & n[65:33]);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    // One APB transfer; a read leaves its expectation for the watcher.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [32:0] e,
        input logic [32:0] m);
        int n;
        n = 0;
        @(posedge mclk);
        if (!wr)
        begin
            notes.push_back({m, e});
        end
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= e[31:0];
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1 && n < 64)
        begin
            @(posedge mclk);
            n++;
        end
        if (n >= 64)
        begin
            mismatches++;
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Watcher: every completed read is held against the oldest note.
    always @(posedge mclk)
    begin
        if (psel && penable && pready && !pwrite)
        begin
            cmp_rd({pslverr, prdata}, notes.pop_front());
        end
    end

    // Wait cyc cycles, clear status, let the detector run cyc more cycles (at least one reference period), then read.
    task automatic detect(input logic [32:0] e, input int cyc);
        repeat (cyc) @(posedge mclk);
        apb(1'b1, `SPLS_ADDR_STATUS, 33'hF, 33'h0);
        repeat (cyc) @(posedge mclk);
        apb(1'b0, `SPLS_ADDR_STATUS, e, 33'h10000000C);
    endtask

    initial
    begin
        void'($urandom(32'h6210B63C));
        repeat (20) @(posedge mclk);
        arst_n <= 1'b1;
        apb(1'b0, `SPLS_ADDR_MASK, 33'h0, ALL);
        apb(1'b0, `SPLS_ADDR_WORD, 33'hFFFF, ALL);
        apb(1'b0, 12'h00C, 33'h100000000, ALL);
        w1 = 16'($urandom());
        w1[13:0] = 14'h0008;
        host.send(w1, 1'b1);
        host.pulse();
        fin_on <= 1'b1;
        apb(1'b0, `SPLS_ADDR_WORD, {17'h0, w1}, ALL);
        cmp_bit(sw1_oe, ~w1[15]);
        cmp_bit(sw2_oe, ~w1[14]);
        // Load event raises, masks and clears the interrupt.
        apb(1'b1, `SPLS_ADDR_MASK, 33'h1, 33'h0);
        repeat (4) @(posedge mclk);
        cmp_bit(irq, 1'b1);
        apb(1'b1, `SPLS_ADDR_MASK, 33'h0, 33'h0);
        repeat (4) @(posedge mclk);
        cmp_bit(irq, 1'b0);
        apb(1'b1, `SPLS_ADDR_MASK, 33'h1, 33'h0);
        apb(1'b1, `SPLS_ADDR_STATUS, 33'h1, 33'h0);
        repeat (4) @(posedge mclk);
        cmp_bit(irq, 1'b0);
        apb(1'b0, `SPLS_ADDR_STATUS, 33'h0, 33'h100000001);
        detect(33'h4, 300);
        w2 = 16'($urandom());
        w2[13:0] = 14'h0020;
        host.send(w2, 1'b1);
        apb(1'b0, `SPLS_ADDR_WORD, {17'h0, w1}, ALL);
        cmp_bit(sw1_oe, ~w1[15]);
        host.pulse();
        apb(1'b0, `SPLS_ADDR_WORD, {17'h0, w2}, ALL);
        detect(33'h8, 300);
        // Select 512: the same feedback now leads the slower reference.
        rsel <= 3'h1;
        detect(33'h4, 4500);
        w1 = 16'($urandom());
        w1[13:0] = 14'h0003;
        host.release_strobe();
        host.send(w1, 1'b0);
        apb(1'b0, `SPLS_ADDR_WORD, {17'h0, w1}, ALL);
        close_out();
    end

    // Watchdog: the sequence needs about eleven thousand cycles.
    initial
    begin
        repeat (30000) @(posedge mclk);
        mismatches++;
        close_out();
    end
endmodule
`default_nettype wire
